// >>> verilog/watchdog_timer_dual_source.sv
// dual-source watchdog timer with an AHB-Lite register slave
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "wdt_defs.svh"
// Operation
// RQ1: unprotected prescaler runs from cpu clock, counting down
// RQ2: prescaler divides 16 or 128, or 2
// RQ3: field 11b gives 3FFFh, 00b 03FFh
// RQ4: field 01b gives 0FFFh, 10b 1FFFh
// RQ5: reload on reset, underflow, 00h-then-FFh
// RQ6: prescaler cleared only by reset
// RQ7: auto-start bit 1 halts until start write
// RQ8: auto-start bit 0 counts from reset release
// RQ9: auto-start option bit not program writable
// RQ10: unprotected counter freezes in wait, stop
// RQ11: underflow gives interrupt or reset by action bit
// RQ12: software refreshes only while counter runs
// RQ13: protected mode counts on low-speed oscillator
// RQ14: protected mode has no prescaler, counts down
// RQ15: protected counter ignores wait and stop
// RQ16: protection on forces oscillator and reset action
// RQ17: option bit 0 keeps protection set
// RQ18: refresh outside window is an incorrect write
// RQ19: option bit 0 enables protection after reset
// RQ20: incomplete sequence never reloads counter
module watchdog_timer_dual_source
  import wdt_pkg::*;
#(
  parameter int LOCO_DIV = `LOCO_DIV_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] option_byte_main,
  input wire logic [7:0] option_byte_second,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic wdt_irq,
  output logic wdt_reset,
  output logic osc_on
);

  // ---------------------------------------------------------------
  // state and helper terms
  // ---------------------------------------------------------------
  wdt_state_s s_q;
  wdt_state_s s_d;
  logic hready_q;
  logic run;
  logic loco_tick;
  logic pre_en;
  logic ptick;
  logic tick;
  logic [6:0] pre_lim;
  logic [1:0] per_sel;
  logic [13:0] reload_val;
  logic [16:0] win_prod;
  logic [13:0] win_thr;
  logic in_window;
  logic wr_refresh;
  logic seq_done;
  logic fault;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // timebases
  // ---------------------------------------------------------------
  // while the straps are latched the live pins choose the period, so
  // an auto-started first period is already the requested length
  assign per_sel = (s_q.ph == PH_CAPTURE) ? option_byte_second[1:0] :
    s_q.opt_sec[1:0];
  // underflow count from the period field of the second option byte
  always_comb begin
    unique case (per_sel)
      2'b00: reload_val = `UF_PER_00; // RQ3
      2'b01: reload_val = `UF_PER_01; // RQ4
      2'b10: reload_val = `UF_PER_10; // RQ4
      2'b11: reload_val = `UF_PER_11; // RQ3
    endcase
  end

  // the low-speed oscillator is an enable pulse, so the whole block
  // stays on hclk; a stopped cpu clock is not modelled here
  assign run = (s_q.ph == PH_RUNNING);
  assign loco_tick = s_q.prot &&
    (s_q.loco == `LOCO_W'(LOCO_DIV - 1)); // RQ13
  assign pre_lim = s_q.lsel ? `PRE_LIM_LOW :
    (s_q.psel ? `PRE_LIM_128 : `PRE_LIM_16); // RQ2
  assign pre_en = run && !s_q.prot &&
    !(wait_mode || stop_mode); // RQ1 RQ10
  assign ptick = pre_en && (s_q.pre >= pre_lim);
  // protected mode bypasses the prescaler entirely
  assign tick = s_q.prot ? (run && loco_tick) : ptick; // RQ14 RQ15

  // refresh window: the last quarter, half, three quarters or all
  assign win_prod = 17'(reload_val) * 17'({1'b0, s_q.opt_sec[3:2]} + 3'd1);
  assign win_thr = win_prod[15:2];
  assign in_window = (s_q.cnt <= win_thr); // RQ18

  // ---------------------------------------------------------------
  // refresh sequence decode
  // ---------------------------------------------------------------
  assign wr_refresh = s_q.wr_pend && (s_q.waddr == `OFF_REFRESH);
  // a refresh sequence completed while halted is ignored: software must not do that
  assign seq_done = wr_refresh && run && s_q.armed &&
    (hwdata[7:0] == `SEQ_SECOND); // RQ5 RQ12 RQ20
  assign fault = seq_done && !in_window; // RQ18

  // read data selected in the address phase, registered for output
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[4:0])
      `OFF_REFRESH: rd_mux[13:0] = s_q.cnt;
      `OFF_WDCTRL: rd_mux[`BIT_PSEL] = s_q.psel;
      `OFF_CLKCTL: rd_mux[`BIT_LSEL] = s_q.lsel;
      `OFF_PMODE1: rd_mux[`BIT_ACT] = s_q.act;
      `OFF_PROTCTL: rd_mux[`BIT_PROT] = s_q.prot;
      `OFF_STATUS: begin
        rd_mux[13:0] = s_q.cnt;
        rd_mux[`ST_RUN] = run;
        rd_mux[`ST_PROT] = s_q.prot;
        rd_mux[`ST_ARMED] = s_q.armed;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.rst = 1'b0;
    // oscillator divider runs only while protection holds it on
    s_d.loco = (!s_q.prot || loco_tick) ? '0 : s_q.loco + 1'b1;
    // prescaler wraps on its own; refresh never touches it
    if (pre_en) begin
      s_d.pre = ptick ? '0 : s_q.pre + 1'b1; // RQ6
    end
    // first cycle after reset: latch the option bytes as straps
    if (s_q.ph == PH_CAPTURE) begin
      s_d.opt_main = option_byte_main;
      s_d.opt_sec = option_byte_second;
      s_d.prot = !option_byte_main[`BIT_PROT_OPT]; // RQ17 RQ19
      s_d.ph = option_byte_main[`BIT_AUTO] ?
        PH_HALTED : PH_RUNNING; // RQ7 RQ8
      s_d.cnt = `UF_PER_11;
    end
    if (s_q.ph == PH_CAPTURE || s_q.ph == PH_HALTED) begin
      s_d.cnt = reload_val; // RQ5
    end
    // counting and underflow
    if (tick) begin
      if (s_q.cnt == 14'h0000) begin
        s_d.cnt = reload_val; // RQ5
        s_d.rst = s_q.act; // RQ11
        s_d.irq = !s_q.act; // RQ11
      end else begin
        s_d.cnt = s_q.cnt - 1'b1; // RQ1 RQ14
      end
    end
    // register writes land in the data phase
    if (s_q.wr_pend) begin
      unique case (s_q.waddr)
        `OFF_REFRESH: begin
          s_d.armed = (hwdata[7:0] == `SEQ_FIRST); // RQ20
        end
        `OFF_START: begin
          if (s_q.ph == PH_HALTED) begin
            s_d.ph = PH_RUNNING; // RQ7
          end
        end
        `OFF_WDCTRL: s_d.psel = hwdata[`BIT_PSEL]; // RQ2
        `OFF_CLKCTL: s_d.lsel = hwdata[`BIT_LSEL]; // RQ2
        `OFF_PMODE1: s_d.act = hwdata[`BIT_ACT]; // RQ11
        `OFF_PROTCTL: begin
          // clearing is refused while the strap demands protection
          if (hwdata[`BIT_PROT]) begin
            s_d.prot = 1'b1; // RQ16
          end else if (s_q.opt_main[`BIT_PROT_OPT]) begin
            s_d.prot = 1'b0; // RQ17
          end
        end
        default: s_d.armed = s_q.armed;
      endcase
    end
    // refresh completion overrides the count of the same cycle
    if (seq_done && in_window) begin
      s_d.cnt = reload_val; // RQ5
    end
    // a refresh outside the window takes the underflow action but does not reload the count
    if (fault) begin
      s_d.rst = s_q.act; // RQ18
      s_d.irq = !s_q.act; // RQ18
    end
    // the option byte copy is never written by the bus
    s_d.act = s_d.act || s_d.prot; // RQ16 RQ9
    // ahb address phase capture
    s_d.wr_pend = hsel && htrans[1] && hready && hwrite;
    s_d.waddr = haddr[4:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      s_d.rdata = rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ph <= PH_CAPTURE;
      s_q.cnt <= `UF_PER_11;
      hready_q <= 1'b1;
    end else begin
      s_q <= s_d;
      hready_q <= 1'b1;
    end
  end

  // outputs straight from flops; zero-wait slave, always OKAY
  assign hreadyout = hready_q;
  assign hresp = s_q.armed & 1'b0;
  assign hrdata = s_q.rdata;
  assign wdt_irq = s_q.irq;
  assign wdt_reset = s_q.rst;
  assign osc_on = s_q.prot; // RQ16

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_arm;
    s_q.armed && run;
  endsequence
  sequence seq_second_ok;
    wr_refresh && (hwdata[7:0] == `SEQ_SECOND) && in_window;
  endsequence

  chk_prot_forces_act: assert property (@(posedge hclk) // RQ16
    disable iff (!hresetn) s_q.prot |-> s_q.act && osc_on)
    else $error("protection without reset action");
  chk_strap_halts: assert property (@(posedge hclk) // RQ7
    disable iff (!hresetn) (s_q.ph == PH_CAPTURE) &&
    option_byte_main[0] |=> (s_q.ph == PH_HALTED))
    else $error("watchdog not halted after reset");
  chk_strap_runs: assert property (@(posedge hclk) // RQ8
    disable iff (!hresetn) (s_q.ph == PH_CAPTURE) &&
    !option_byte_main[0] |=> run)
    else $error("watchdog did not auto-start");
  chk_strap_prot: assert property (@(posedge hclk) // RQ19
    disable iff (!hresetn) (s_q.ph == PH_CAPTURE) &&
    !option_byte_main[7] |=> s_q.prot [*2])
    else $error("protection strap ignored");
  chk_freeze_wait: assert property (@(posedge hclk) // RQ10
    disable iff (!hresetn) run && !s_q.prot && wait_mode &&
    !seq_done |=> $stable(s_q.cnt))
    else $error("counter moved in wait mode");
  chk_prot_counts: assert property (@(posedge hclk) // RQ15
    disable iff (!hresetn) tick && s_q.prot && stop_mode &&
    (s_q.cnt != 14'h0000) && !seq_done |=>
    s_q.cnt == $past(s_q.cnt) - 14'h0001)
    else $error("protected counter paused");
  chk_underflow_act: assert property (@(posedge hclk) // RQ11
    disable iff (!hresetn) tick && (s_q.cnt == 14'h0000) |=>
    (wdt_reset == $past(s_q.act)) && (wdt_irq != wdt_reset))
    else $error("wrong underflow action");
  chk_prescale_16: assert property (@(posedge hclk) // RQ2
    disable iff (!hresetn) pre_en && !s_q.lsel && !s_q.psel &&
    (s_q.pre == 7'h0F) |-> tick ##1 (s_q.pre == 7'h00))
    else $error("prescaler did not wrap at 16");
  chk_refresh_reload: assert property (@(posedge hclk) // RQ5
    disable iff (!hresetn) seq_arm ##0 seq_second_ok |=>
    (s_q.cnt == reload_val))
    else $error("refresh sequence did not reload");
  chk_seq_disarm: assert property (@(posedge hclk) // RQ20
    disable iff (!hresetn) wr_refresh &&
    (hwdata[7:0] != 8'h00) |=> !s_q.armed)
    else $error("sequence stayed armed");

  // ---------------------------------------------------------------
  // period, fault, count, prescaler, low-power, protection and start checks
  // ---------------------------------------------------------------
  // an underflow is a tick that finds the counter already at zero
  sequence seq_underflow;
    tick && (s_q.cnt == 14'h0000);
  endsequence
  // a completed sequence that landed outside the window
  sequence seq_late_refresh;
    seq_done && !in_window;
  endsequence

  // a refresh fault takes the same action as an underflow
  chk_fault_action: assert property (@(posedge hclk) // RQ18
    disable iff (!hresetn) seq_late_refresh |=>
    (wdt_reset == $past(s_q.act)) && (wdt_irq == !$past(s_q.act)))
    else $error("refresh fault gave wrong action");
  // a fault must not restart the period
  chk_fault_no_reload: assert property (@(posedge hclk) // RQ18
    disable iff (!hresetn) seq_late_refresh ##0 !tick |=> $stable(s_q.cnt))
    else $error("refresh fault reloaded the counter");
  // underflow reloads the count chosen by the period field
  chk_period_reload: assert property (@(posedge hclk) // RQ3 RQ4 RQ5
    disable iff (!hresetn) seq_underflow |=> (s_q.cnt == reload_val))
    else $error("underflow reloaded wrong count");
  // the first count after capture already follows the period field
  chk_first_period: assert property (@(posedge hclk) // RQ3 RQ8
    disable iff (!hresetn) (s_q.ph == PH_CAPTURE) |=>
    (s_q.cnt == reload_val))
    else $error("first period ignores the period field");
  // a tick away from zero and without a refresh steps the counter down by one
  chk_count_down: assert property (@(posedge hclk) // RQ1 RQ14
    disable iff (!hresetn) tick && (s_q.cnt != 14'h0000) && !seq_done |=>
    (s_q.cnt == $past(s_q.cnt) - 14'h0001))
    else $error("counter did not step down");
  // a refresh leaves the prescaler running on
  chk_prescale_keep: assert property (@(posedge hclk) // RQ6
    disable iff (!hresetn) seq_done && pre_en && !ptick |=>
    (s_q.pre == $past(s_q.pre) + 7'h01))
    else $error("refresh disturbed the prescaler");
  // wait and stop hold an unprotected count where it is
  chk_stop_no_tick: assert property (@(posedge hclk) // RQ10
    disable iff (!hresetn) !s_q.prot && (wait_mode || stop_mode) |-> !tick)
    else $error("unprotected counter ticked in a low-power mode");
  // in protected mode ticks come only from the oscillator divider
  chk_prot_no_pre: assert property (@(posedge hclk) // RQ13 RQ14
    disable iff (!hresetn) s_q.prot && tick |-> loco_tick && !pre_en)
    else $error("protected count used the prescaler");
  // a halted watchdog waits for a start write, and starts on one
  chk_halt_holds: assert property (@(posedge hclk) // RQ7
    disable iff (!hresetn) (s_q.ph == PH_HALTED) &&
    !(s_q.wr_pend && (s_q.waddr == `OFF_START)) |=> (s_q.ph == PH_HALTED))
    else $error("watchdog left halt without a start write");
  chk_start_write: assert property (@(posedge hclk) // RQ7
    disable iff (!hresetn) (s_q.ph == PH_HALTED) && s_q.wr_pend &&
    (s_q.waddr == `OFF_START) |=> run)
    else $error("start write did not start the watchdog");

endmodule

// >>> verilog/wdt_defs.svh
// constants for the dual-source watchdog: offsets, fields, counts
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_REFRESH 5'h00
`define OFF_START 5'h04
`define OFF_WDCTRL 5'h08
`define OFF_CLKCTL 5'h0C
`define OFF_PMODE1 5'h10
`define OFF_PROTCTL 5'h14
`define OFF_STATUS 5'h18
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_PSEL 7
`define BIT_LSEL 7
`define BIT_ACT 2
`define BIT_PROT 7
`define BIT_AUTO 0
`define BIT_PROT_OPT 7
`define ST_RUN 16
`define ST_PROT 17
`define ST_ARMED 18
// ---------------------------------------------------------------
// values and counts
// ---------------------------------------------------------------
`define SEQ_FIRST 8'h00
`define SEQ_SECOND 8'hFF
`define UF_PER_00 14'h03FF
`define UF_PER_01 14'h0FFF
`define UF_PER_10 14'h1FFF
`define UF_PER_11 14'h3FFF
`define PRE_LIM_LOW 7'h01
`define PRE_LIM_16 7'h0F
`define PRE_LIM_128 7'h7F
`define CLK_FREQ_KHZ 100000
`define LOCO_FREQ_KHZ 125
`define LOCO_DIV_CYC (`CLK_FREQ_KHZ / `LOCO_FREQ_KHZ)
`define LOCO_W 10
`endif

// >>> verilog/wdt_pkg.sv
// types shared by the dual-source watchdog
package wdt_pkg;
  // ---------------------------------------------------------------
  // run phase and full block state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_CAPTURE, PH_HALTED, PH_RUNNING} run_e;
  typedef struct packed {
    run_e ph;
    logic [7:0] opt_main;
    logic [7:0] opt_sec;
    logic [6:0] pre;
    logic [13:0] cnt;
    logic [9:0] loco;
    logic armed;
    logic psel;
    logic lsel;
    logic act;
    logic prot;
    logic irq;
    logic rst;
    logic [31:0] rdata;
    logic wr_pend;
    logic [4:0] waddr;
  } wdt_state_s;
endpackage

// >>> verilog/unused_placeholder_note.sv
// intentionally empty compilation unit
`timescale 1ns/100ps

// >>> tb/tb_watchdog_timer_dual_source.sv
// self-checking bench for the dual-source watchdog timer
`timescale 1ns/100ps
`include "wdt_defs.svh"
module tb_watchdog_timer_dual_source;
  // ---------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] option_byte_main;
  logic [7:0] option_byte_second;
  logic wait_mode;
  logic stop_mode;
  logic wdt_irq;
  logic wdt_reset;
  logic osc_on;
  int errors;
  int samples_checked;
  int cycles;
  int seed;
  int n;
  logic [31:0] r;
  logic [31:0] a;
  logic [13:0] per_tab [4];

  // the one slave drives the bus ready
  assign hready = hreadyout;

  watchdog_timer_dual_source #(.LOCO_DIV(4)) watchdog_timer_dual_source_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .option_byte_main(option_byte_main),
    .option_byte_second(option_byte_second), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset),
    .osc_on(osc_on));

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ceiling sized for two slow /16 underflow periods plus margin
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [4:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {27'h000_0000, ad};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask

  task automatic rd(input logic [4:0] ad, output logic [31:0] q);
    bus(1'b0, ad, 32'h0000_0000, q);
  endtask

  // bounded wait for an underflow event; n is the cycle count
  task automatic wait_evt(input logic on_rst, output int cnt);
    cnt = 0;
    do begin
      @(posedge hclk);
      cnt++;
    end while ((on_rst ? wdt_reset : wdt_irq) !== 1'b1 && cnt < 40000);
  endtask

  task automatic do_reset(input logic [7:0] m, input logic [7:0] s);
    option_byte_main <= m;
    option_byte_second <= s;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    per_tab = '{14'h03ff, 14'h0fff, 14'h1fff, 14'h3fff};
    seed = 32'hcaf9;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    option_byte_main = 8'hff;
    option_byte_second = 8'hff;
    // reload value per period field while halted after reset
    for (int k = 0; k < 4; k++) begin
      do_reset(8'hff, {6'h3f, k[1:0]});
      rd(`OFF_REFRESH, r);
      check("period", r & 32'h3fff, {18'h0, per_tab[k]});
      rd(`OFF_STATUS, r);
      check("halted", r[`ST_RUN], 1'b0);
    end
    $display("test period_select done");
    do_reset(8'hff, 8'hfc);
    wr(`OFF_START, $random(seed));
    rd(`OFF_STATUS, r);
    check("started", r[`ST_RUN], 1'b1);
    rd(`OFF_REFRESH, a);
    repeat (64) @(posedge hclk);
    rd(`OFF_REFRESH, r);
    check("down", r < a, 1'b1);
    $display("test start done");
    // underflow spacing is (m+1) ticks of the divided clock
    wr(`OFF_CLKCTL, 32'h0000_0080);
    wait_evt(1'b0, n);
    wait_evt(1'b0, n);
    check("div2", n, 32'd2048);
    wr(`OFF_CLKCTL, 32'h0000_0000);
    wait_evt(1'b0, n);
    wait_evt(1'b0, n);
    check("div16", n, 32'd16384);
    $display("test prescaler done");
    wr(`OFF_CLKCTL, 32'h0000_0080);
    repeat (200) @(posedge hclk);
    wr(`OFF_REFRESH, 32'h0000_0000);
    wr(`OFF_REFRESH, 32'h0000_00ff);
    rd(`OFF_REFRESH, r);
    check("reload", r >= 32'h3fd, 1'b1);
    repeat (200) @(posedge hclk);
    wr(`OFF_REFRESH, 32'h0000_0000);
    wr(`OFF_REFRESH, 32'h0000_0001 + ($random(seed) & 32'h7f));
    wr(`OFF_REFRESH, 32'h0000_00ff);
    rd(`OFF_REFRESH, r);
    check("partial", r < 32'h3c0, 1'b1);
    $display("test refresh done");
    wait_mode <= 1'b1;
    rd(`OFF_REFRESH, a);
    repeat (50) @(posedge hclk);
    rd(`OFF_REFRESH, r);
    check("frozen", r, a);
    wait_mode <= 1'b0;
    wr(`OFF_PMODE1, 32'h0000_0004);
    wait_evt(1'b1, n);
    check("rst_evt", n < 3000, 1'b1);
    $display("test freeze_action done");
    wr(`OFF_PMODE1, 32'h0000_0000);
    wr(`OFF_PROTCTL, 32'h0000_0080);
    // osc_on is launched by the edge that ends the write; look one later
    @(posedge hclk);
    check("osc", osc_on, 1'b1);
    rd(`OFF_PMODE1, r);
    check("forced", r[`BIT_ACT], 1'b1);
    stop_mode <= 1'b1;
    rd(`OFF_REFRESH, a);
    repeat (100) @(posedge hclk);
    rd(`OFF_REFRESH, r);
    check("prot_run", r !== a, 1'b1);
    stop_mode <= 1'b0;
    $display("test protect done");
    do_reset(8'h7e, 8'hfc);
    check("prot_rst", osc_on, 1'b1);
    rd(`OFF_STATUS, r);
    check("auto", r[`ST_RUN], 1'b1);
    wr(`OFF_PROTCTL, 32'h0000_0000);
    rd(`OFF_PROTCTL, r);
    check("locked", r[`BIT_PROT], 1'b1);
    $display("test strap done");
    // early refresh is a fault; one in the final 25% window reloads
    do_reset(8'hff, 8'hf0);
    wr(`OFF_START, $random(seed));
    wr(`OFF_REFRESH, 32'h0000_0000);
    wr(`OFF_REFRESH, 32'h0000_00ff);
    wait_evt(1'b0, n);
    check("fault", n, 32'd1);
    wr(`OFF_CLKCTL, 32'h0000_0080);
    repeat (1700) @(posedge hclk);
    rd(`OFF_REFRESH, a);
    check("late", a <= 32'h00ff, 1'b1);
    wr(`OFF_REFRESH, 32'h0000_0000);
    wr(`OFF_REFRESH, 32'h0000_00ff);
    rd(`OFF_REFRESH, r);
    check("win_reload", r >= 32'h3fd, 1'b1);
    $display("test window done");
    finish_test();
  end
endmodule
